// ---- design/codec_ctl_pkg.sv ----
// Package: control word layout, register codes, field positions and decoded types
package codec_ctl_pkg;

  // ------------------------------------------------------------------
  // Control word layout
  // ------------------------------------------------------------------
  localparam int WORD_W      = 16;   // Serial control word width
  localparam int DEV_HI      = 15;   // Device address top bit
  localparam int DEV_LO      = 13;   // Device address low bit
  localparam int RW_BIT      = 12;   // Read/write bit, low = write
  localparam int REG_HI      = 11;   // Register address top bit
  localparam int REG_LO      = 9;    // Register address low bit
  localparam int DATA_HI     = 7;    // Data byte top bit

  localparam logic [2:0] REG_NOP   = 3'h0;  // No operation
  localparam logic [2:0] REG_CTL3  = 3'h3;  // test_flag_power_control
  localparam logic [2:0] REG_CTL4  = 3'h4;  // adc_dac_gain_control
  localparam logic [7:0] CTL3_RST  = 8'h00; // Reset value
  localparam logic [7:0] CTL4_RST  = 8'h00; // Reset value

  // ------------------------------------------------------------------
  // Field positions in test_flag_power_control
  // ------------------------------------------------------------------
  localparam int TEST_HI   = 7;
  localparam int TEST_LO   = 6;
  localparam int CONT_BIT  = 5;
  localparam int FSRC_BIT  = 4;
  localparam int FVAL_BIT  = 3;
  localparam int PWR_HI    = 2;
  localparam int PWR_LO    = 1;
  localparam int FMT_BIT   = 0;

  // Gain nibble positions in adc_dac_gain_control
  localparam int ADC_GAIN_HI = 7;
  localparam int ADC_GAIN_LO = 4;
  localparam int DAC_GAIN_HI = 3;
  localparam int DAC_GAIN_LO = 0;

  // Gain code values
  localparam logic [3:0] GAIN_MUTE = 4'hf;
  localparam logic [3:0] GAIN_ZERO = 4'h0;

  // ------------------------------------------------------------------
  // Decoded types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    TEST_NORMAL, TEST_ANA_LOOP, TEST_DIG_LOOP, TEST_EVENT_MON
  } test_mode_t;

  typedef enum logic [1:0] {
    PWR_ALL_ON, PWR_ADC_OFF, PWR_DAC_OFF, PWR_SOFT_DOWN
  } power_mode_t;

  // Signed gain in dB plus mute flag for one gain stage
  typedef struct packed {
    logic              mute;
    logic signed [7:0] gain_db;
  } gain_setting_t;

  // Decoded controls of the first register
  typedef struct packed {
    test_mode_t  test_mode;
    logic        cont_xfer;
    logic        flag_from_reg;
    power_mode_t power_mode;
    logic        adc_16bit;
  } ctl3_dec_t;

endpackage : codec_ctl_pkg

// ---- design/gain_code_decode.sv ----
// Gain code decoder: 4-bit code to dB value and mute flag
module gain_code_decode
  import codec_ctl_pkg::*;
(
  input  wire logic [3:0]    code,
  output gain_setting_t      setting
);

  // ------------------------------------------------------------------
  // Lookup of dB values
  // ------------------------------------------------------------------
  logic signed [7:0] db_w;  // Decoded gain in dB

  // Constant table; mute code carries 0 dB alongside mute flag
  always_comb begin
    case (code)
      4'he:    db_w = 8'sd24;
      4'hd:    db_w = 8'sd18;
      4'hc:    db_w = 8'sd12;
      4'hb:    db_w = 8'sd9;
      4'ha:    db_w = 8'sd6;
      4'h9:    db_w = 8'sd3;
      4'h8:    db_w = -8'sd3;
      4'h7:    db_w = -8'sd6;
      4'h6:    db_w = -8'sd9;
      4'h5:    db_w = -8'sd12;
      4'h4:    db_w = -8'sd18;
      4'h3:    db_w = -8'sd24;
      4'h2:    db_w = -8'sd30;
      4'h1:    db_w = -8'sd36;
      default: db_w = 8'sd0;
    endcase
  end

  assign setting.mute    = (code == GAIN_MUTE);
  assign setting.gain_db = db_w;

endmodule // gain_code_decode

// ---- design/ctl_word_decode.sv ----
// Control word decoder: address match and register write strobes
module ctl_word_decode
  import codec_ctl_pkg::*;
(
  input  wire logic [WORD_W-1:0] word,
  input  wire logic              word_valid,
  input  wire logic [2:0]        own_addr,
  output logic                   wr_ctl3,
  output logic                   wr_ctl4,
  output logic                   rd_hit
);

  // ------------------------------------------------------------------
  // Field split
  // ------------------------------------------------------------------
  wire logic       addr_hit = (word[DEV_HI:DEV_LO] == own_addr);
  wire logic       is_write = ~word[RW_BIT];
  wire logic [2:0] reg_code = word[REG_HI:REG_LO];

  // Code 000 and unknown codes select nothing
  assign wr_ctl3 = word_valid & addr_hit & is_write & (reg_code == REG_CTL3);
  assign wr_ctl4 = word_valid & addr_hit & is_write & (reg_code == REG_CTL4);
  assign rd_hit  = word_valid & addr_hit & ~is_write
                 & ((reg_code == REG_CTL3) | (reg_code == REG_CTL4));

endmodule // ctl_word_decode

// ---- design/codec_control_regs.sv ----
// Control registers three and four of the voice codec, written by serial words
// How it works
// [R1] Test field selects normal, loopbacks, event monitor
// [R2] Continuous transfer only honoured on cascade master
// [R3] Flag source bit picks stored or secondary flag
// [R4] Lowest bit selects 16-bit ADC word format
// [R5] Power field: on, ADC off, DAC off, down
// [R6] ADC gain nibble all ones mutes ADC stage
// [R7] ADC codes 1110..1000 give 24 down to -3 dB
// [R8] ADC codes 0111..0001 give -6 down to -36 dB
// [R9] ADC code 0000 gives 0 dB, reset value
// [R10] DAC gain nibble all ones mutes DAC stage
// [R11] DAC codes 1110..1000 give 24 down to -3 dB
// [R12] DAC codes 0111..0001 give -6 down to -36 dB
// [R13] DAC code 0000 gives 0 dB, reset value
// [R14] Word: device address, RW low write, register, data
// [R15] Code 011 first register, 100 gain, 000 nop
module codec_control_regs
  import codec_ctl_pkg::*;
(
  input  wire logic              core_clk,        // Master clock, 10 MHz
  input  wire logic              rst_n,           // Synchronous reset, active low
  input  wire logic [WORD_W-1:0] ctl_word,        // Assembled serial control word
  input  wire logic              ctl_word_valid,  // One-cycle strobe with ctl_word
  input  wire logic [2:0]        own_addr,        // Cascade address of this device
  input  wire logic              is_master,       // Device is cascade master
  input  wire logic              sec_comm_flag,   // Secondary communication flag
  output logic [7:0]             ctl3_q,          // Stored first register
  output logic [7:0]             ctl4_q,          // Stored gain register
  output logic                   read_hit,        // Read of a held register seen
  output ctl3_dec_t              ctl3_dec,        // Decoded first register
  output logic                   event_mon_wr,    // Event monitor on a write word
  output logic                   flag_out,        // General flag output
  output logic                   adc_enable,      // ADC channel runs
  output logic                   dac_enable,      // DAC channel runs
  output gain_setting_t          adc_gain,        // ADC stage setting
  output gain_setting_t          dac_gain         // DAC stage setting
);

  // ------------------------------------------------------------------
  // Word decode
  // ------------------------------------------------------------------
  logic wr_ctl3;   // Write strobe for first register
  logic wr_ctl4;   // Write strobe for gain register
  logic rd_hit_w;  // Read of a held register

  ctl_word_decode u_dec (
    .word       (ctl_word),
    .word_valid (ctl_word_valid),
    .own_addr   (own_addr),
    .wr_ctl3    (wr_ctl3),        // [R14] [R15]
    .wr_ctl4    (wr_ctl4),
    .rd_hit     (rd_hit_w)
  );

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  logic [7:0] ctl3_r;   // test_flag_power_control
  logic [7:0] ctl4_r;   // adc_dac_gain_control
  logic [7:0] ctl3_nxt;
  logic [7:0] ctl4_nxt;
  logic       rd_r;     // Registered read indication

  // Data byte is the low eight bits of a matching write word
  assign ctl3_nxt = wr_ctl3 ? ctl_word[DATA_HI:0] : ctl3_r;  // [R14]
  assign ctl4_nxt = wr_ctl4 ? ctl_word[DATA_HI:0] : ctl4_r;  // [R15]

  // Both registers return to zero on reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl3_r <= CTL3_RST;
      ctl4_r <= CTL4_RST;
      rd_r   <= 1'b0;
    end else begin
      ctl3_r <= ctl3_nxt;
      ctl4_r <= ctl4_nxt;
      rd_r   <= rd_hit_w;
    end
  end

  assign ctl3_q   = ctl3_r;
  assign ctl4_q   = ctl4_r;
  assign read_hit = rd_r;

  // ------------------------------------------------------------------
  // First register decode
  // ------------------------------------------------------------------
  wire logic [1:0] test_bits = ctl3_r[TEST_HI:TEST_LO];
  wire logic [1:0] pwr_bits  = ctl3_r[PWR_HI:PWR_LO];

  assign ctl3_dec.test_mode     = test_mode_t'(test_bits);           // [R1]
  // A slave ignores the bit; the host must set it only on the master
  assign ctl3_dec.cont_xfer     = ctl3_r[CONT_BIT] & is_master;      // [R2]
  assign ctl3_dec.flag_from_reg = ctl3_r[FSRC_BIT];
  assign ctl3_dec.power_mode    = power_mode_t'(pwr_bits);           // [R5]
  assign ctl3_dec.adc_16bit     = ctl3_r[FMT_BIT];                   // [R4]

  // Event monitor acts on write words only
  assign event_mon_wr = (ctl3_dec.test_mode == TEST_EVENT_MON)
                      & ctl_word_valid & ~ctl_word[RW_BIT];          // [R1]

  // Channel enables from the power field
  assign adc_enable = (ctl3_dec.power_mode == PWR_ALL_ON)
                    | (ctl3_dec.power_mode == PWR_DAC_OFF);          // [R5]
  assign dac_enable = (ctl3_dec.power_mode == PWR_ALL_ON)
                    | (ctl3_dec.power_mode == PWR_ADC_OFF);          // [R5]

  // Flag output is a data output, so it comes from a flip-flop
  logic flag_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= ctl3_r[FSRC_BIT] ? ctl3_r[FVAL_BIT] : sec_comm_flag; // [R3]
    end
  end
  assign flag_out = flag_r;

  // ------------------------------------------------------------------
  // Gain stages
  // ------------------------------------------------------------------
  // Each stage sees only its own nibble, so the same decoder is instanced for each
  wire logic [3:0] adc_code = ctl4_r[ADC_GAIN_HI:ADC_GAIN_LO];  // ADC gain nibble
  wire logic [3:0] dac_code = ctl4_r[DAC_GAIN_HI:DAC_GAIN_LO];  // DAC gain nibble

  gain_code_decode u_adc_gain (
    .code    (adc_code),       // [R6] [R7] [R8] [R9]
    .setting (adc_gain)
  );

  gain_code_decode u_dac_gain (
    .code    (dac_code),       // [R10] [R11] [R12] [R13]
    .setting (dac_gain)
  );

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_wr3;
    @(posedge core_clk) disable iff (!rst_n)
    wr_ctl3 |=> ctl3_r == $past(ctl_word[DATA_HI:0]);
  endproperty
  a_wr3: assert property (p_wr3) else $error("first register not written"); // [R14]

  property p_nop;
    @(posedge core_clk) disable iff (!rst_n)
    (ctl_word_valid && ctl_word[REG_HI:REG_LO] == REG_NOP) |=>
      (ctl3_r == $past(ctl3_r)) && (ctl4_r == $past(ctl4_r));
  endproperty
  a_nop: assert property (p_nop) else $error("nop word changed a register"); // [R15]

  property p_rd;
    @(posedge core_clk) disable iff (!rst_n)
    (ctl_word_valid && ctl_word[RW_BIT]) |=> ctl3_r == $past(ctl3_r);
  endproperty
  a_rd: assert property (p_rd) else $error("read word wrote register"); // [R14]

  property p_flag;
    @(posedge core_clk) disable iff (!rst_n)
    ctl3_r[FSRC_BIT] |=> flag_out == $past(ctl3_r[FVAL_BIT]);
  endproperty
  a_flag: assert property (p_flag) else $error("flag not from stored value"); // [R3]

  property p_flag_sec;
    @(posedge core_clk) disable iff (!rst_n)
    !ctl3_r[FSRC_BIT] |=> flag_out == $past(sec_comm_flag);
  endproperty
  a_flag_sec: assert property (p_flag_sec) else $error("flag not secondary"); // [R3]

  property p_cont;
    @(posedge core_clk) disable iff (!rst_n)
    !is_master |-> !ctl3_dec.cont_xfer;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode on slave"); // [R2]

  property p_pwr;
    @(posedge core_clk) disable iff (!rst_n)
    (pwr_bits == 2'h3) |-> !adc_enable && !dac_enable;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-down left channel on"); // [R5]

  property p_adc_mute;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_ctl4 && ctl_word[ADC_GAIN_HI:ADC_GAIN_LO] == GAIN_MUTE) |=> adc_gain.mute;
  endproperty
  a_adc_mute: assert property (p_adc_mute) else $error("ADC not muted"); // [R6]

  property p_dac_gain;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_ctl4 && ctl_word[DAC_GAIN_HI:DAC_GAIN_LO] == 4'he) |=>
      dac_gain.gain_db == 8'sd24 && !dac_gain.mute;
  endproperty
  a_dac_gain: assert property (p_dac_gain) else $error("DAC 24 dB wrong"); // [R11]

  property p_adc_low;
    @(posedge core_clk) disable iff (!rst_n)
    (adc_code == 4'h1) |-> adc_gain.gain_db == -8'sd36;
  endproperty
  a_adc_low: assert property (p_adc_low) else $error("ADC -36 dB wrong"); // [R8]

  property p_zero;
    @(posedge core_clk)
    !rst_n |=> adc_gain.gain_db == 8'sd0 && dac_gain.gain_db == 8'sd0;
  endproperty
  a_zero: assert property (p_zero) else $error("reset gain not 0 dB"); // [R9] [R13]

  property p_fmt;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_ctl3 && ctl_word[FMT_BIT]) |=> ctl3_dec.adc_16bit;
  endproperty
  a_fmt: assert property (p_fmt) else $error("16-bit format not set"); // [R4]

  // Gain register takes the data byte of a matching write
  property p_wr4;
    @(posedge core_clk) disable iff (!rst_n)
    wr_ctl4 |=> ctl4_r == $past(ctl_word[DATA_HI:0]);
  endproperty
  a_wr4: assert property (p_wr4) else $error("gain register not written"); // [R15]

  // Event monitor strobe only on a write word while the mode is set
  property p_ev_wr;
    @(posedge core_clk) disable iff (!rst_n)
    event_mon_wr |-> ctl_word_valid && !ctl_word[RW_BIT] && test_bits == TEST_EVENT_MON;
  endproperty
  a_ev_wr: assert property (p_ev_wr) else $error("event monitor on wrong word"); // [R1]

  // A read of the gain register at this address is marked a cycle later
  property p_rd_hit;
    @(posedge core_clk) disable iff (!rst_n)
    (ctl_word_valid && ctl_word[RW_BIT] && ctl_word[DEV_HI:DEV_LO] == own_addr
      && ctl_word[REG_HI:REG_LO] == REG_CTL4) |=> read_hit;
  endproperty
  a_rd_hit: assert property (p_rd_hit) else $error("read not marked"); // [R14]

  // Disabling the ADC leaves the DAC running
  property p_adc_off;
    @(posedge core_clk) disable iff (!rst_n)
    (ctl3_dec.power_mode == PWR_ADC_OFF) |-> !adc_enable && dac_enable;
  endproperty
  a_adc_off: assert property (p_adc_off) else $error("ADC disable wrong"); // [R5]

  // Disabling the DAC leaves the ADC running
  property p_dac_off;
    @(posedge core_clk) disable iff (!rst_n)
    (ctl3_dec.power_mode == PWR_DAC_OFF) |-> adc_enable && !dac_enable;
  endproperty
  a_dac_off: assert property (p_dac_off) else $error("DAC disable wrong"); // [R5]

  // ADC code 1110 gives the largest gain, not mute
  property p_adc_high;
    @(posedge core_clk) disable iff (!rst_n)
    (adc_code == 4'he) |-> adc_gain.gain_db == 8'sh18 && !adc_gain.mute;
  endproperty
  a_adc_high: assert property (p_adc_high) else $error("ADC 24 dB wrong"); // [R7]

  // ADC code zero is unity gain
  property p_adc_zero;
    @(posedge core_clk) disable iff (!rst_n)
    (adc_code == GAIN_ZERO) |-> adc_gain.gain_db == 8'sh00 && !adc_gain.mute;
  endproperty
  a_adc_zero: assert property (p_adc_zero) else $error("ADC 0 dB wrong"); // [R9]

  // DAC all-ones code mutes the stage
  property p_dac_mute;
    @(posedge core_clk) disable iff (!rst_n)
    (dac_code == GAIN_MUTE) |-> dac_gain.mute;
  endproperty
  a_dac_mute: assert property (p_dac_mute) else $error("DAC not muted"); // [R10]

  // A low DAC code gives its attenuation
  property p_dac_low;
    @(posedge core_clk) disable iff (!rst_n)
    (dac_code == 4'h2) |-> dac_gain.gain_db == -8'sh1e && !dac_gain.mute;
  endproperty
  a_dac_low: assert property (p_dac_low) else $error("DAC -30 dB wrong"); // [R12]

  // DAC code zero is unity gain
  property p_dac_zero;
    @(posedge core_clk) disable iff (!rst_n)
    (dac_code == GAIN_ZERO) |-> dac_gain.gain_db == 8'sh00 && !dac_gain.mute;
  endproperty
  a_dac_zero: assert property (p_dac_zero) else $error("DAC 0 dB wrong"); // [R13]

  c_ev: cover property (@(posedge core_clk) event_mon_wr);
  c_cont: cover property (@(posedge core_clk) ctl3_dec.cont_xfer);
  c_rd: cover property (@(posedge core_clk) read_hit);
  c_mute: cover property (@(posedge core_clk) adc_gain.mute && dac_gain.mute);
  c_loop: cover property (@(posedge core_clk) ctl3_dec.test_mode == TEST_DIG_LOOP);

endmodule // codec_control_regs

// ---- testbench/ctl_word_host.sv ----
// DSP host model that issues serial control words to the register block
module ctl_word_host
  import codec_ctl_pkg::*;
(
  input  wire logic         core_clk,       // Master clock
  output logic [WORD_W-1:0] ctl_word,       // Assembled control word
  output logic              ctl_word_valid  // One-cycle word strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------------
  // Idle state
  // ------------------------------------------------------------------
  initial begin
    ctl_word       = '0;
    ctl_word_valid = 1'b0;
  end

  // ------------------------------------------------------------------
  // Word issue
  // ------------------------------------------------------------------
  // One word per call, driven at the falling edge for a single cycle
  task automatic send(input logic [2:0] dev, input logic rw, input logic [2:0] rsel,
                      input logic [7:0] data);
    logic [WORD_W-1:0] w;
    w = {dev, rw, rsel, 1'b0, data};
    @(negedge core_clk);
    ctl_word       <= w;
    ctl_word_valid <= 1'b1;
    @(negedge core_clk);
    // Released word shows garbage so a stale value can never be reused
    ctl_word       <= ~w;
    ctl_word_valid <= 1'b0;
  endtask
endmodule // ctl_word_host

// ---- testbench/codec_control_regs_tb.sv ----
// Self-checking testbench for the control register block
module codec_control_regs_tb import codec_ctl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic              core_clk;       // 10 MHz clock
  logic              rst_n;          // Sync reset
  logic [2:0]        own_addr;       // Cascade address
  logic              is_master;      // Cascade master strap
  logic              sec_comm_flag;  // Secondary flag
  logic [WORD_W-1:0] ctl_word;       // From host model
  logic              ctl_word_valid; // From host model
  logic [7:0]        ctl3_q, ctl4_q; // Stored registers
  logic              read_hit, event_mon_wr, flag_out, adc_enable, dac_enable;
  ctl3_dec_t         ctl3_dec;       // Decoded first register
  gain_setting_t     adc_gain, dac_gain;
  logic              ev_seen;        // event_mon_wr at the word edge
  int                fail_count = 0;
  int                tests_run = 0;
  int                cycles = 0;
  // Expected dB per gain code; code f is mute with 0 dB
  localparam int DB_TAB[16] = '{0, -36, -30, -24, -18, -12, -9, -6, -3, 3, 6, 9, 12, 18, 24, 0};

  ctl_word_host host_u (.core_clk(core_clk), .ctl_word(ctl_word), .ctl_word_valid(ctl_word_valid));
  codec_control_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .ctl_word(ctl_word),
    .ctl_word_valid(ctl_word_valid), .own_addr(own_addr), .is_master(is_master),
    .sec_comm_flag(sec_comm_flag), .ctl3_q(ctl3_q), .ctl4_q(ctl4_q), .read_hit(read_hit),
    .ctl3_dec(ctl3_dec), .event_mon_wr(event_mon_wr), .flag_out(flag_out),
    .adc_enable(adc_enable), .dac_enable(dac_enable), .adc_gain(adc_gain), .dac_gain(dac_gain));

  // ------------------------------------------------------------------
  // Clock, capture and watchdog
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Comb strobe is only meaningful while the word is on the port
  always @(posedge core_clk) begin
    if (ctl_word_valid) begin
      ev_seen <= event_mon_wr;
    end
  end
  // The whole run needs well under 1000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [8:0] exp_gain(input logic [3:0] c);
    return {c == 4'hf, 8'(DB_TAB[c])};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk("ctl3_q", 9'h0, ctl3_q);
    chk("ctl4_q", 9'h0, ctl4_q);
    chk("adc_gain", exp_gain(4'h0), adc_gain);
    chk("dac_gain", exp_gain(4'h0), dac_gain);
    chk("enables", 9'h3, {adc_enable, dac_enable});
    chk("flag_out", 9'h0, flag_out);
    chk("read_hit", 9'h0, read_hit);
    $display("test reset done");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      host_u.send(own_addr, 1'b0, REG_CTL3, {m[1:0], 3'h0, m[1:0], m[0]});
      chk("test_mode", m, ctl3_dec.test_mode);
      chk("power_mode", m, ctl3_dec.power_mode);
      chk("adc_enable", !m[0], adc_enable);
      chk("dac_enable", !m[1], dac_enable);
      chk("adc_16bit", m[0], ctl3_dec.adc_16bit);
      chk("ctl3_q", {m[1:0], 3'h0, m[1:0], m[0]}, ctl3_q);
    end
    host_u.send(own_addr + 3'h1, 1'b0, REG_NOP, 8'h00);
    chk("event_mon_wr", 9'h1, ev_seen);
    host_u.send(own_addr, 1'b1, REG_CTL3, 8'h00);
    chk("event_mon_rd", 9'h0, ev_seen);
    chk("read_hit", 9'h1, read_hit);
    host_u.send(own_addr, 1'b0, REG_CTL3, 8'h00);
    $display("test modes done");
  endtask
  task automatic t_flag_cont();
    is_master = 1'b0;
    host_u.send(own_addr, 1'b0, REG_CTL3, 8'h38);
    chk("cont_xfer", 9'h0, ctl3_dec.cont_xfer);
    chk("flag_from_reg", 9'h1, ctl3_dec.flag_from_reg);
    @(negedge core_clk);
    chk("flag_out", 9'h1, flag_out);
    is_master = 1'b1;
    sec_comm_flag = 1'b1;
    host_u.send(own_addr, 1'b0, REG_CTL3, 8'h20);
    chk("cont_xfer", 9'h1, ctl3_dec.cont_xfer);
    chk("flag_from_reg", 9'h0, ctl3_dec.flag_from_reg);
    @(negedge core_clk);
    chk("flag_out", 9'h1, flag_out);
    sec_comm_flag = 1'b0;
    @(negedge core_clk);
    chk("flag_out", 9'h0, flag_out);
    $display("test flag done");
  endtask
  task automatic t_gain();
    for (int i = 0; i < 16; i++) begin
      host_u.send(own_addr, 1'b0, REG_CTL4, {i[3:0], ~i[3:0]});
      chk("adc_gain", exp_gain(i[3:0]), adc_gain);
      chk("dac_gain", exp_gain(~i[3:0]), dac_gain);
    end
    $display("test gain done");
  endtask
  task automatic t_refuse();
    logic [2:0] bad[6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    host_u.send(own_addr, 1'b0, REG_CTL3, 8'h5a);
    host_u.send(own_addr + 3'h1, 1'b0, REG_CTL3, 8'hff);
    host_u.send(own_addr, 1'b1, REG_CTL4, 8'hff);
    chk("read_hit", 9'h1, read_hit);
    foreach (bad[k]) host_u.send(own_addr, 1'b0, bad[k], 8'hff);
    chk("read_hit", 9'h0, read_hit);
    chk("ctl3_q", 9'h5a, ctl3_q);
    chk("ctl4_q", 9'hf0, ctl4_q);
    $display("test refuse done");
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    own_addr = 3'h2;
    is_master = 1'b0;
    sec_comm_flag = 1'b0;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_modes();
    t_flag_cont();
    t_gain();
    t_refuse();
    // Second reset in mid-run must clear the loaded registers
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    report_and_stop();
  end
endmodule // codec_control_regs_tb
